// ==== logic/decade_counter8.sv ====
`include "qpct_consts.svh"

module decade_counter8 (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Control
    input  wire logic        clr,
    input  wire logic        inc,
    // State
    output logic [31:0]      count,
    output logic             ovf
);
    import qpct_pkg::*;

    cnt_state_s st;
    cnt_state_s next_st;

    function automatic logic [32:0] bcd_inc(input logic [31:0] v);
        logic [31:0] r;
        logic        carry;
        r = v;
        carry = 1'B1;
        for (int i = 0; i < 8; i++) begin
            if (carry) begin
                if (r[i*4 +: 4] == `DIGIT_MAX) begin
                    r[i*4 +: 4] = 4'H0;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] + 4'H1;
                    carry = 1'B0;
                end
            end
        end
        return {carry, r};
    endfunction

    always_comb begin
        logic [32:0] sum;
        sum = 33'H0;
        next_st = st;
        // A clear and an increment in one cycle: clear first, then count from zero
        if (clr) begin
            next_st.count = 32'H0;
            next_st.ovf   = 1'B0;
        end
        if (inc) begin
            sum = bcd_inc(next_st.count);
            next_st.count = sum[31:0];
            if (sum[32]) begin
                next_st.ovf = 1'B1; // RULE_26
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign ovf   = st.ovf;

    a_ovf_sticky: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_26
        ovf && !clr |=> ovf)
        else $error("overflow flag dropped without a clear");
endmodule

// ==== logic/qpct_consts.svh ====
// How it works
// RULE_01 - Blank leading zeros until overflow occurs
// RULE_02 - Tenth-second base on channel 1 lights decimal point
// RULE_03 - Overflow lamp blinks 1 Hz until reset
// RULE_04 - Lamp test lights every segment
// RULE_05 - Dwell waits, resets, restarts; off disables
// RULE_06 - Powers up local; host selects remote
// RULE_07 - Remote ignores all buttons except two
// RULE_08 - Counting lamp: started and master gate
// RULE_09 - Display selector steps 1 to 4, wraps
// RULE_10 - Channel 1 source: tenth, minute, external
// RULE_11 - Preset is mantissa times ten power exponent
// RULE_12 - Zero mantissa disables preset end
// RULE_13 - Stop halts counting; ignored in remote
// RULE_14 - Reset clears all four channels; local only
// RULE_15 - Count starts channels when gates permit
// RULE_16 - Master gate low inhibits all channels
// RULE_17 - Channel gate inhibits its own channel
// RULE_18 - Wide positive external pulse clears channels
// RULE_19 - Event counter host only, never displayed
// RULE_20 - Event source: pulses over 100 ns, 4 kHz
// RULE_21 - Interval output high while counting gate open
// RULE_22 - Channel 1 at preset closes all gates
// RULE_23 - Power-up: cleared, channel 1, zero presets, stopped
// RULE_24 - Auto mode bumps event counter per interval
// RULE_25 - Channel counts only with run and gates
// RULE_26 - Overflow flag sticky until channel reset
`ifndef QPCT_CONSTS_SVH
`define QPCT_CONSTS_SVH

`define CLK_PERIOD_NS   50
`define TENTH_SEC_NS    100000000
`define TICK_CYCLES     (`TENTH_SEC_NS / `CLK_PERIOD_NS)
`define MINUTE_TICKS    10'H258
`define BLINK_TICKS     3'H5
`define DWELL_BASE      7'H05
`define DWELL_STEP      7'H08
`define XRST_MIN_NS     1000
`define XRST_CYCLES     ((`XRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EVT_MIN_NS      100
`define EVT_CYCLES      ((`EVT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESET_RST      4'H0
`define MANT_MAX        4'H9
`define EXP_MAX         4'H7
`define DISP_RST        2'H0
`define DISP_LAST       2'H3
`define DIGIT_MAX       4'H9
`define DP_DIGIT        1
`define BTN_COUNT       0
`define BTN_STOP        1
`define BTN_RESET       2
`define BTN_TBASE       3
`define BTN_MANT        4
`define BTN_EXP         5
`define BTN_DISP        6
`define BTN_W           7

`endif

// ==== logic/qpct_pkg.sv ====
package qpct_pkg;
    typedef enum logic [1:0] {TB_TENTH, TB_MINUTE, TB_EXT} tbase_e;
    typedef enum logic [1:0] {PH_STOP, PH_COUNT, PH_DWELL} phase_e;

    typedef struct packed {
        logic [31:0] count;
        logic        ovf;
    } cnt_state_s;

    typedef struct packed {
        phase_e      phase;
        logic        remote;
        tbase_e      tbase;
        logic [1:0]  disp_sel;
        logic [3:0]  mant;
        logic [3:0]  expo;
        logic [20:0] tick_cnt;
        logic        tick;
        logic [9:0]  min_cnt;
        logic        minute;
        logic [2:0]  blink_cnt;
        logic        blink;
        logic [6:0]  dwell_cnt;
        logic [4:0]  xrst_cnt;
        logic        xrst_done;
        logic [1:0]  evt_cnt;
        logic        evt_done;
        logic [6:0]  btn_prev;
        logic [3:0]  cin_prev;
        logic        clr;
        logic        evt_inc;
        logic [3:0]  ch_inc;
        logic [55:0] disp_seg;
        logic [7:0]  disp_dp;
        logic [6:0]  sel_seg;
        logic [6:0]  mant_seg;
        logic [6:0]  exp_seg;
        logic [3:0]  ovf_led;
        logic        counting_led;
        logic        interval_out;
        logic        remote_led;
        logic        local_led;
        logic [2:0]  tbase_led;
    } core_state_s;
endpackage

// ==== logic/quad_preset_counter_timer.sv ====
`include "qpct_consts.svh"

module quad_preset_counter_timer #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Front panel buttons, high while pressed
    input  wire logic        btn_count,
    input  wire logic        btn_stop,
    input  wire logic        btn_reset,
    input  wire logic        btn_tbase,
    input  wire logic        btn_mant,
    input  wire logic        btn_exp,
    input  wire logic        btn_disp,
    input  wire logic        btn_lamp_test,
    input  wire logic [3:0]  dwell_sel,
    // Host control strobes and levels
    input  wire logic        host_remote,
    input  wire logic        host_local,
    input  wire logic        host_count,
    input  wire logic        host_stop,
    input  wire logic        host_reset,
    input  wire logic        host_event_auto,
    input  wire logic        host_event_ext,
    input  wire logic        host_event_clear,
    // Rear panel signals
    input  wire logic        master_gate,
    input  wire logic [3:0]  channel_gate,
    input  wire logic [3:1]  counter_input,
    input  wire logic        external_timer_input,
    input  wire logic        ext_reset_in,
    input  wire logic        event_input,
    // Displays and lamps
    output logic [55:0]      disp_seg,
    output logic [7:0]       disp_dp,
    output logic [6:0]       sel_seg,
    output logic [6:0]       mant_seg,
    output logic [6:0]       exp_seg,
    output logic [3:0]       ovf_led,
    output logic             counting_led,
    output logic             remote_led,
    output logic             local_led,
    output logic [2:0]       tbase_led,
    output logic             interval_out,
    // Host readback
    output logic [31:0]      event_count,
    output logic             event_ovf
);
    import qpct_pkg::*;

    core_state_s st;
    core_state_s next_st;
    logic [31:0] ch_count [4];
    logic [3:0]  ch_ovf;
    logic [31:0] preset_bcd;
    logic        preset_hit;
    logic        end_now;
    logic [6:0]  btn_now;
    logic [6:0]  press;
    logic [6:0]  lpress;

    function automatic logic [6:0] seg7(input logic [3:0] d);
        case (d)
            4'H0:    return 7'H3F;
            4'H1:    return 7'H06;
            4'H2:    return 7'H5B;
            4'H3:    return 7'H4F;
            4'H4:    return 7'H66;
            4'H5:    return 7'H6D;
            4'H6:    return 7'H7D;
            4'H7:    return 7'H07;
            4'H8:    return 7'H7F;
            4'H9:    return 7'H6F;
            default: return 7'H00;
        endcase
    endfunction

    function automatic logic rising(input logic now, input logic prev);
        return now && !prev;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            decade_counter8 u_ch (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .clr      (st.clr),
                .inc      (st.ch_inc[g]),
                .count    (ch_count[g]),
                .ovf      (ch_ovf[g])
            );
        end
    endgenerate

    // Kept apart from the display path on purpose
    decade_counter8 u_event (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clr      (host_event_clear),
        .inc      (st.evt_inc),
        .count    (event_count),
        .ovf      (event_ovf)
    ); // RULE_19

    assign btn_now = {btn_disp, btn_exp, btn_mant, btn_tbase, btn_reset, btn_stop, btn_count};
    always_comb begin
        for (int i = 0; i < `BTN_W; i++) begin
            press[i] = rising(btn_now[i], st.btn_prev[i]);
        end
    end
    assign lpress = st.remote ? (press & (7'H1 << `BTN_DISP)) : press; // RULE_07

    always_comb begin
        preset_bcd = 32'H0;
        preset_bcd[st.expo[2:0]*4 +: 4] = st.mant; // RULE_11
    end
    assign preset_hit = (st.mant != `PRESET_RST) && (ch_count[0] == preset_bcd); // RULE_12
    // A pending clear still shows the old count; ending on it would loop the dwell
    assign end_now    = (st.phase == PH_COUNT) && preset_hit && !st.clr; // RULE_22

    always_comb begin
        logic [31:0] shown;
        logic        keep;
        logic        run;
        logic        ch1_edge;
        next_st = st;
        shown = 32'H0;
        keep = 1'B0;
        run = 1'B0;
        ch1_edge = 1'B0;
        next_st.btn_prev = btn_now;
        next_st.cin_prev = {counter_input, external_timer_input};
        next_st.clr = 1'B0;
        next_st.evt_inc = 1'B0;

        // Time base: tenth-second ticks, minute ticks and a 1 Hz blink phase
        next_st.tick = 1'B0;
        next_st.minute = 1'B0;
        if (st.tick_cnt == 21'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = 21'H0;
            next_st.tick = 1'B1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 21'H1;
        end
        if (st.tick) begin
            if (st.min_cnt == 10'(`MINUTE_TICKS - 10'H1)) begin
                next_st.min_cnt = 10'H0;
                next_st.minute = 1'B1;
            end else begin
                next_st.min_cnt = st.min_cnt + 10'H1;
            end
            if (st.blink_cnt == 3'(`BLINK_TICKS - 3'H1)) begin
                next_st.blink_cnt = 3'H0;
                next_st.blink = !st.blink; // RULE_03
            end else begin
                next_st.blink_cnt = st.blink_cnt + 3'H1;
            end
        end

        if (host_remote) begin
            next_st.remote = 1'B1; // RULE_06
        end else if (host_local) begin
            next_st.remote = 1'B0;
        end

        if (lpress[`BTN_DISP]) begin
            next_st.disp_sel = (st.disp_sel == `DISP_LAST) ? `DISP_RST
                             : st.disp_sel + 2'H1; // RULE_09
        end
        if (lpress[`BTN_TBASE]) begin
            case (st.tbase)
                TB_TENTH:  next_st.tbase = TB_MINUTE;
                TB_MINUTE: next_st.tbase = TB_EXT;
                default:   next_st.tbase = TB_TENTH;
            endcase // RULE_10
        end
        if (lpress[`BTN_MANT]) begin
            next_st.mant = (st.mant == `MANT_MAX) ? `PRESET_RST : st.mant + 4'H1; // RULE_11
        end
        if (lpress[`BTN_EXP]) begin
            next_st.expo = (st.expo == `EXP_MAX) ? `PRESET_RST : st.expo + 4'H1; // RULE_11
        end

        // External reset acts once per pulse, only after the minimum width
        if (!ext_reset_in) begin
            next_st.xrst_cnt = 5'H0;
            next_st.xrst_done = 1'B0;
        end else if (st.xrst_cnt != 5'(`XRST_CYCLES)) begin
            next_st.xrst_cnt = st.xrst_cnt + 5'H1;
        end else if (!st.xrst_done) begin
            next_st.xrst_done = 1'B1;
            next_st.clr = 1'B1; // RULE_18
        end

        // Sequencer
        case (st.phase)
            PH_STOP: begin
                if ((lpress[`BTN_COUNT] || host_count) && master_gate) begin
                    next_st.phase = PH_COUNT; // RULE_15
                end
            end
            PH_COUNT: begin
                if (lpress[`BTN_STOP] || host_stop) begin
                    next_st.phase = PH_STOP; // RULE_13
                end else if (end_now) begin
                    next_st.evt_inc = host_event_auto; // RULE_24
                    if (dwell_sel != 4'H0) begin
                        next_st.phase = PH_DWELL; // RULE_05
                        next_st.dwell_cnt = `DWELL_BASE
                                          + 7'(dwell_sel - 4'H1) * `DWELL_STEP;
                    end else begin
                        next_st.phase = PH_STOP;
                    end
                end
            end
            PH_DWELL: begin
                if (lpress[`BTN_STOP] || host_stop) begin
                    next_st.phase = PH_STOP;
                end else if (st.tick) begin
                    if (st.dwell_cnt == 7'H0) begin
                        next_st.clr = 1'B1; // RULE_05
                        next_st.phase = PH_COUNT;
                    end else begin
                        next_st.dwell_cnt = st.dwell_cnt - 7'H1;
                    end
                end
            end
            default: next_st.phase = PH_STOP;
        endcase
        if (lpress[`BTN_RESET] || host_reset) begin
            next_st.clr = 1'B1; // RULE_14
            next_st.phase = PH_STOP; // RULE_08
        end

        // Event input: qualify width, count once per pulse when in external mode
        if (!event_input) begin
            next_st.evt_cnt = 2'H0;
            next_st.evt_done = 1'B0;
        end else if (st.evt_cnt != 2'(`EVT_CYCLES)) begin
            next_st.evt_cnt = st.evt_cnt + 2'H1;
        end else if (!st.evt_done) begin
            next_st.evt_done = 1'B1;
            next_st.evt_inc = next_st.evt_inc || host_event_ext;
        end

        // Channel edges, gated by run state, master gate and own gate
        run = (st.phase == PH_COUNT) && master_gate && !end_now && !next_st.clr; // RULE_16
        case (st.tbase)
            TB_TENTH:  ch1_edge = st.tick;
            TB_MINUTE: ch1_edge = st.minute;
            default:   ch1_edge = rising(external_timer_input, st.cin_prev[0]);
        endcase
        next_st.ch_inc[0] = run && channel_gate[0] && ch1_edge; // RULE_25
        for (int i = 1; i < 4; i++) begin
            next_st.ch_inc[i] = run && channel_gate[i]
                              && rising(counter_input[i], st.cin_prev[i]); // RULE_17
        end

        // Lamps and outputs, all registered
        next_st.counting_led = (next_st.phase == PH_COUNT) && master_gate; // RULE_08
        next_st.interval_out = (next_st.phase == PH_COUNT) && master_gate; // RULE_21
        next_st.remote_led = next_st.remote;
        next_st.local_led = !next_st.remote;
        next_st.tbase_led = 3'H1 << next_st.tbase;
        for (int i = 0; i < 4; i++) begin
            next_st.ovf_led[i] = ch_ovf[i] && st.blink; // RULE_03
        end

        shown = ch_count[st.disp_sel];
        keep = ch_ovf[st.disp_sel]; // RULE_01
        for (int i = 7; i >= 0; i--) begin
            keep = keep || (shown[i*4 +: 4] != 4'H0) || (i == 0)
                 || (i == `DP_DIGIT && st.disp_sel == `DISP_RST && st.tbase == TB_TENTH);
            next_st.disp_seg[i*7 +: 7] = keep ? seg7(shown[i*4 +: 4]) : 7'H00; // RULE_01
        end
        next_st.disp_dp = 8'H0;
        if (st.disp_sel == `DISP_RST && st.tbase == TB_TENTH) begin
            next_st.disp_dp[`DP_DIGIT] = 1'B1; // RULE_02
        end
        next_st.sel_seg = seg7({2'H0, st.disp_sel} + 4'H1);
        next_st.mant_seg = seg7(st.mant);
        next_st.exp_seg = seg7(st.expo);
        if (btn_lamp_test) begin
            next_st.disp_seg = '1; // RULE_04
            next_st.disp_dp = '1;
            next_st.sel_seg = '1;
            next_st.mant_seg = '1;
            next_st.exp_seg = '1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0; // RULE_23
            st.local_led <= 1'B1;
            st.tbase_led <= 3'H1;
        end else begin
            st <= next_st;
        end
    end

    assign disp_seg     = st.disp_seg;
    assign disp_dp      = st.disp_dp;
    assign sel_seg      = st.sel_seg;
    assign mant_seg     = st.mant_seg;
    assign exp_seg      = st.exp_seg;
    assign ovf_led      = st.ovf_led;
    assign counting_led = st.counting_led;
    assign remote_led   = st.remote_led;
    assign local_led    = st.local_led;
    assign tbase_led    = st.tbase_led;
    assign interval_out = st.interval_out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_end_dwell;
        end_now && !lpress[`BTN_RESET] && !lpress[`BTN_STOP] && !host_reset && !host_stop
        && dwell_sel != 4'H0;
    endsequence
    sequence s_end_nodwell;
        end_now && !btn_reset && !host_reset && !host_stop && dwell_sel == 4'H0;
    endsequence

    a_dwell_enter: assert property (s_end_dwell |=> st.phase == PH_DWELL) // RULE_05
        else $error("interval end with dwell did not enter dwell");
    a_dwell_off: assert property (s_end_nodwell |=> st.phase == PH_STOP ##1 !interval_out) // RULE_05
        else $error("interval end without dwell did not stop");
    a_remote_count: assert property (st.remote && st.phase == PH_STOP && !host_count // RULE_07
        |=> st.phase == PH_STOP)
        else $error("remote mode started counting from panel");
    a_stop_halts: assert property (!st.remote && press[`BTN_STOP] // RULE_13
        |=> st.phase == PH_STOP ##1 !counting_led)
        else $error("stop button did not halt counting");
    a_reset_clears: assert property (!st.remote && press[`BTN_RESET] // RULE_14
        |=> st.clr ##1 ch_count[0] == 32'H0 && ch_count[3] == 32'H0)
        else $error("reset button did not clear channels");
    a_mant_zero: assert property (st.phase == PH_COUNT && st.mant == `PRESET_RST // RULE_12
        && !lpress[`BTN_STOP] && !lpress[`BTN_RESET] && !host_stop && !host_reset
        |=> st.phase == PH_COUNT)
        else $error("zero mantissa ended an interval");
    a_lamp_all: assert property (btn_lamp_test |=> &disp_seg && &sel_seg && &mant_seg) // RULE_04
        else $error("lamp test left a segment dark");
    a_disp_wrap: assert property (lpress[`BTN_DISP] && st.disp_sel == `DISP_LAST // RULE_09
        |=> st.disp_sel == `DISP_RST ##1 sel_seg == seg7(4'H1))
        else $error("display selector did not wrap to channel 1");
    a_gate_qual: assert property (st.ch_inc[2] // RULE_25
        |-> $past(st.phase == PH_COUNT && master_gate && channel_gate[2]))
        else $error("channel counted while gated off");
    a_interval_gate: assert property (!master_gate |=> !interval_out && !counting_led) // RULE_21
        else $error("interval output high with master gate closed");
endmodule

// ==== verif/far_side_model.sv ====
module far_side_model (
    // Clock
    input  wire logic       core_clk,
    // Sources that force a gate low; a released gate floats high
    input  wire logic       mg_low,
    input  wire logic [3:0] cg_low,
    // Lines into the counter
    output logic            master_gate,
    output logic [3:0]      channel_gate,
    output logic            external_timer_input,
    output logic [3:1]      counter_input,
    output logic            ext_reset_in,
    output logic            event_input
);
    timeunit 1ns;
    timeprecision 1ns;

    assign master_gate  = ~mg_low;
    assign channel_gate = ~cg_low;

    initial begin
        {event_input, counter_input, external_timer_input} = 5'H00;
        ext_reset_in = 1'b0;
    end

    // Three cycles high, three low: wide enough and edges well apart
    task automatic pulse(input logic [4:0] m);
        {event_input, counter_input, external_timer_input} = m;
        repeat (3) @(posedge core_clk);
        #5 {event_input, counter_input, external_timer_input} = 5'H00;
        repeat (3) @(posedge core_clk);
        #5;
    endtask

    // Only a positive level acts on the reset line
    task automatic xrst(input int n);
        ext_reset_in = 1'b1;
        repeat (n) @(posedge core_clk);
        #5 ext_reset_in = 1'b0;
        @(posedge core_clk);
        #5;
    endtask
endmodule

// ==== verif/tb_quad_preset_counter_timer.sv ====
module tb_quad_preset_counter_timer;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [6:0]  btn      = 7'H00;
    logic [6:0]  hs       = 7'H00;
    logic [3:0]  dwell    = 4'H0;
    logic [3:0]  ovf_led;
    logic        lamp     = 1'b0;
    logic        ev_ext   = 1'b0;
    logic        mg_low   = 1'b0;
    logic [3:0]  cg_low   = 4'H0;
    logic        master_gate, external_timer_input, ext_reset_in, event_input;
    logic [3:0]  channel_gate;
    logic [3:1]  counter_input;
    logic [55:0] disp_seg;
    logic [7:0]  disp_dp;
    logic [6:0]  sel_seg, mant_seg, exp_seg;
    logic        counting_led, remote_led, local_led, interval_out, event_ovf;
    logic [2:0]  tbase_led;
    logic [31:0] event_count;
    int          err_total = 0;
    int          tests_run = 0;

    localparam logic [6:0] seg_tab [10] = '{7'H3F, 7'H06, 7'H5B, 7'H4F, 7'H66,
                                            7'H6D, 7'H7D, 7'H07, 7'H7F, 7'H6F};
    // Button index, then sel_seg, tbase_led and mant_seg after the press
    localparam logic [19:0] rows [10] = '{{3'H0, 7'H06, 3'H1, 7'H3F},
        {3'H6, 7'H5B, 3'H1, 7'H3F}, {3'H6, 7'H4F, 3'H1, 7'H3F},
        {3'H6, 7'H66, 3'H1, 7'H3F}, {3'H6, 7'H06, 3'H1, 7'H3F},
        {3'H3, 7'H06, 3'H2, 7'H3F}, {3'H3, 7'H06, 3'H4, 7'H3F},
        {3'H2, 7'H06, 3'H4, 7'H3F},
        {3'H4, 7'H06, 3'H4, 7'H06}, {3'H4, 7'H06, 3'H4, 7'H5B}};

    always #25 core_clk = ~core_clk;

    quad_preset_counter_timer #(.TICK_CYCLES(20)) quad_preset_counter_timer_i (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .btn_count(btn[0]), .btn_stop(btn[1]), .btn_reset(btn[2]), .btn_tbase(btn[3]),
        .btn_mant(btn[4]), .btn_exp(btn[5]), .btn_disp(btn[6]),
        .btn_lamp_test(lamp), .dwell_sel(dwell),
        .host_remote(hs[0]), .host_local(hs[1]), .host_count(hs[2]),
        .host_stop(hs[4]), .host_reset(hs[5]), .host_event_auto(hs[6]),
        .host_event_ext(ev_ext), .host_event_clear(hs[3]),
        .master_gate(master_gate), .channel_gate(channel_gate),
        .counter_input(counter_input), .external_timer_input(external_timer_input),
        .ext_reset_in(ext_reset_in), .event_input(event_input),
        .disp_seg(disp_seg), .disp_dp(disp_dp), .sel_seg(sel_seg), .mant_seg(mant_seg),
        .exp_seg(exp_seg), .ovf_led(ovf_led), .counting_led(counting_led),
        .remote_led(remote_led), .local_led(local_led), .tbase_led(tbase_led),
        .interval_out(interval_out), .event_count(event_count), .event_ovf(event_ovf));

    far_side_model far_side_model_i (
        .core_clk(core_clk), .mg_low(mg_low), .cg_low(cg_low),
        .master_gate(master_gate), .channel_gate(channel_gate),
        .external_timer_input(external_timer_input), .counter_input(counter_input),
        .ext_reset_in(ext_reset_in), .event_input(event_input));

    // Expected display with leading zeros blanked, digit0 always shown
    function automatic logic [55:0] dsp(input int v);
        dsp = '0;
        for (int i = 0; i < 8; i++) begin
            if (v > 0 || i == 0) dsp[i*7+:7] = seg_tab[v % 10];
            v = v / 10;
        end
    endfunction

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask

    // Outputs settle two edges after the taking edge
    task automatic press(input int i);
        btn[i] = 1'b1;
        cyc(1);
        btn[i] = 1'b0;
        cyc(2);
    endtask

    task automatic hstb(input int i);
        hs[i] = 1'b1;
        cyc(1);
        hs[i] = 1'b0;
        cyc(2);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic give_verdict();
        $display("%0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        err_total++;
        $display("FAIL watchdog expected 0 seen 1");
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #5 sys_rst = 1'b0;
        cyc(2);
        chk("leds", {local_led, remote_led, counting_led, interval_out}, 4'H8);
        chk("tbase_led", tbase_led, 3'H1);
        chk("sel_seg", sel_seg, seg_tab[1]);
        chk("preset", {mant_seg, exp_seg}, {seg_tab[0], seg_tab[0]});
        chk("digit0", disp_seg[6:0], seg_tab[0]);
        chk("upper", disp_seg[55:14], 42'H0);
        chk("disp_dp", disp_dp, 8'H02);
        chk("ovf", {ovf_led, event_ovf}, 5'H00);
        done("reset");
        foreach (rows[k]) begin
            press(int'(rows[k][19:17]));
            chk("sel_seg", sel_seg, rows[k][16:10]);
            chk("tbase_led", tbase_led, rows[k][9:7]);
            chk("mant_seg", mant_seg, rows[k][6:0]);
        end
        for (int n = 1; n <= 8; n++) begin
            press(5);
            chk("exp_seg", exp_seg, seg_tab[n % 8]);
        end
        chk("disp_dp", disp_dp, 8'H00);
        done("table");
        cg_low = 4'H8;
        press(0);
        chk("run", {counting_led, interval_out}, 2'H3);
        press(1);
        chk("run", {counting_led, interval_out}, 2'H0);
        press(0);
        far_side_model_i.pulse(5'H0F);
        cyc(3);
        chk("ch1", disp_seg, dsp(1));
        far_side_model_i.pulse(5'H0F);
        cyc(3);
        chk("run", {counting_led, interval_out}, 2'H0);
        far_side_model_i.pulse(5'H0F);
        cyc(3);
        chk("ch1", disp_seg, dsp(2));
        press(6);
        chk("ch2", disp_seg, dsp(2));
        press(6);
        press(6);
        chk("ch4", disp_seg, dsp(0));
        done("count");
        press(6);
        mg_low = 1'b1;
        press(2);
        chk("ch1", disp_seg, dsp(0));
        press(0);
        mg_low = 1'b0;
        cyc(2);
        chk("run", {counting_led, interval_out}, 2'H0);
        done("gate");
        hstb(0);
        chk("mode", {remote_led, local_led}, 2'H2);
        press(0);
        chk("run", counting_led, 1'b0);
        press(6);
        chk("sel_seg", sel_seg, seg_tab[2]);
        lamp = 1'b1;
        cyc(2);
        chk("lamp", {sel_seg, disp_seg}, {63{1'b1}});
        lamp = 1'b0;
        hstb(2);
        far_side_model_i.pulse(5'H03);
        cyc(3);
        chk("ch2", disp_seg, dsp(1));
        press(2);
        chk("ch2", disp_seg, dsp(1));
        far_side_model_i.xrst(10);
        chk("ch2", disp_seg, dsp(1));
        far_side_model_i.xrst(25);
        cyc(2);
        chk("ch2", disp_seg, dsp(0));
        done("remote");
        ev_ext = 1'b1;
        far_side_model_i.pulse(5'H10);
        cyc(5000);
        far_side_model_i.pulse(5'H10);
        cyc(3);
        chk("event_count", event_count, 32'H2);
        chk("ch2", disp_seg, dsp(0));
        hstb(3);
        chk("event_count", event_count, 32'H0);
        hstb(1);
        chk("mode", {remote_led, local_led}, 2'H1);
        done("event");
        hstb(4);
        chk("run", {counting_led, interval_out}, 2'H0);
        dwell = 4'H1;
        hs[6] = 1'b1;
        press(0);
        far_side_model_i.pulse(5'H03);
        far_side_model_i.pulse(5'H03);
        cyc(3);
        chk("dwell", {counting_led, disp_seg}, {1'b0, dsp(2)});
        cyc(150);
        chk("dwell", {counting_led, disp_seg}, {1'b1, dsp(0)});
        chk("event_count", event_count, 32'H1);
        hs[6] = 1'b0;
        far_side_model_i.pulse(5'H03);
        cyc(3);
        chk("ch2", disp_seg, dsp(1));
        hstb(5);
        chk("ch2", {counting_led, disp_seg}, {1'b0, dsp(0)});
        done("dwell");
        give_verdict();
    end
endmodule
